// ==== logic/dmacr_params.svh ====
`ifndef DMACR_PARAMS_SVH
`define DMACR_PARAMS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define DMACR_MAIN_BASE      32'h0000_2400
`define DMACR_CH0_BASE       32'h0000_2440
`define DMACR_CH_STRIDE      32'h0000_0040
`define DMACR_NUM_CH         7
`define DMACR_OFF_MAIN_CTL   6'h00
`define DMACR_OFF_STAGED     6'h04

// ----------------------------------------
// Channel bank offsets
// ----------------------------------------
`define DMACR_OFF_CH_ENABLE  6'h00
`define DMACR_OFF_CURSOR     6'h04
`define DMACR_OFF_LIMIT      6'h08
`define DMACR_OFF_PERIPH     6'h0c
`define DMACR_OFF_CONTROL    6'h10
`define DMACR_OFF_FLAGS      6'h14
`define DMACR_OFF_MASK       6'h18
`define DMACR_OFF_TEST       6'h1c
`define DMACR_OFF_CRC_EN     6'h20
`define DMACR_OFF_CRC_VALUE  6'h24
`define DMACR_OFF_CRC_POST   6'h28
`define DMACR_OFF_CRC_TEST   6'h2c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DMACR_BIT_ACTIVATE   0
`define DMACR_BIT_SOFT       1
`define DMACR_BIT_CH_ENABLE  0
`define DMACR_BIT_INC_MEM    16
`define DMACR_SIZE_LSB       20
`define DMACR_SIZE_MSB       22
`define DMACR_ADDR_MASK      32'h00ff_ffff
`define DMACR_WORD_RESET     32'h0000_0000
`define DMACR_FIFO_DEPTH     8

`endif

// ==== logic/dmacr_pkg.sv ====
package dmacr_pkg;

	typedef logic [31:0] dmacr_word_type;
	typedef logic [2:0]  dmacr_chan_type;
	typedef logic [5:0]  dmacr_off_type;

	typedef struct packed {
		dmacr_chan_type channel;
		dmacr_word_type data;
	} dmacr_beat_type;

endpackage : dmacr_pkg

// ==== logic/dmacr_chan_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface dmacr_chan_if;
	logic                     wr;
	dmacr_pkg::dmacr_off_type off;
	dmacr_pkg::dmacr_word_type wdata;
	dmacr_pkg::dmacr_word_type rdata;
	logic                     adv;
	logic                     enable;

	modport host (output wr, output off, output wdata, output adv, input rdata, input enable);
	modport bank (input wr, input off, input wdata, input adv, output rdata, output enable);
endinterface : dmacr_chan_if

`default_nettype wire

// ==== logic/dmacr_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module dmacr_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             clear,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	// Drain side
	output var  logic             out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
	assign out_data   = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (clear) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr    <= wr_ptr + PW'(push);
			rd_ptr    <= rd_ptr + PW'(pop);
			count     <= next_count;
			in_ready  <= next_count != (PW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (reset)
		count <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : dmacr_fifo

`default_nettype wire

// ==== logic/dmacr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmacr_params.svh"

module dmacr_bank #(
	parameter bit HAS_CRC = 1'b0
) (
	// Clock and resets
	input  wire logic   clk_sys,
	input  wire logic   reset,
	input  wire logic   engine_reset,
	// Register and advance carrier
	dmacr_chan_if.bank  bus
);
	dmacr_pkg::dmacr_word_type cursor, limit, periph, control, flags, mask;
	dmacr_pkg::dmacr_word_type crc_en, crc_value, crc_post;
	logic                      enable;

	wire [2:0] size    = control[`DMACR_SIZE_MSB:`DMACR_SIZE_LSB];
	wire       inc_mem = control[`DMACR_BIT_INC_MEM];
	wire       crc_ok  = HAS_CRC;
	wire [31:0] adv_sum = (cursor + {29'h0, size}) & `DMACR_ADDR_MASK;

	assign bus.enable = enable;
	assign bus.rdata =
		(bus.off == `DMACR_OFF_CH_ENABLE) ? {31'h0, enable} :
		(bus.off == `DMACR_OFF_CURSOR)    ? cursor :
		(bus.off == `DMACR_OFF_LIMIT)     ? limit :
		(bus.off == `DMACR_OFF_PERIPH)    ? periph :
		(bus.off == `DMACR_OFF_CONTROL)   ? control :
		(bus.off == `DMACR_OFF_FLAGS)     ? flags :
		(bus.off == `DMACR_OFF_MASK)      ? mask :
		(crc_ok && bus.off == `DMACR_OFF_CRC_EN)    ? crc_en :
		(crc_ok && bus.off == `DMACR_OFF_CRC_VALUE) ? crc_value :
		(crc_ok && bus.off == `DMACR_OFF_CRC_POST)  ? crc_post :
		`DMACR_WORD_RESET;

	wire w_en   = bus.wr && bus.off == `DMACR_OFF_CH_ENABLE;
	wire w_cur  = bus.wr && bus.off == `DMACR_OFF_CURSOR;
	wire w_crc  = bus.wr && crc_ok;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable <= 1'b0;
			cursor <= `DMACR_WORD_RESET;
		end else if (engine_reset) begin
			enable <= 1'b0;
			cursor <= `DMACR_WORD_RESET;
		end else begin
			if (w_en) begin
				enable <= bus.wdata[`DMACR_BIT_CH_ENABLE];
			end
			// Memory side is the slave of the transfer
			if (w_cur) begin
				cursor <= bus.wdata & `DMACR_ADDR_MASK;
			end else if (bus.adv && inc_mem) begin
				cursor <= adv_sum;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			limit   <= `DMACR_WORD_RESET;
			periph  <= `DMACR_WORD_RESET;
			control <= `DMACR_WORD_RESET;
			flags   <= `DMACR_WORD_RESET;
			mask    <= `DMACR_WORD_RESET;
		end else if (engine_reset) begin
			limit   <= `DMACR_WORD_RESET;
			periph  <= `DMACR_WORD_RESET;
			control <= `DMACR_WORD_RESET;
			flags   <= `DMACR_WORD_RESET;
			mask    <= `DMACR_WORD_RESET;
		end else if (bus.wr) begin
			// Fixed offsets within the bank
			if (bus.off == `DMACR_OFF_LIMIT)   limit   <= bus.wdata & `DMACR_ADDR_MASK;
			if (bus.off == `DMACR_OFF_PERIPH)  periph  <= bus.wdata & `DMACR_ADDR_MASK;
			if (bus.off == `DMACR_OFF_CONTROL) control <= bus.wdata;
			if (bus.off == `DMACR_OFF_FLAGS)   flags   <= bus.wdata;
			if (bus.off == `DMACR_OFF_MASK)    mask    <= bus.wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			crc_en    <= `DMACR_WORD_RESET;
			crc_value <= `DMACR_WORD_RESET;
			crc_post  <= `DMACR_WORD_RESET;
		end else if (engine_reset) begin
			crc_en    <= `DMACR_WORD_RESET;
			crc_value <= `DMACR_WORD_RESET;
			crc_post  <= `DMACR_WORD_RESET;
		end else if (w_crc) begin
			if (bus.off == `DMACR_OFF_CRC_EN)    crc_en    <= bus.wdata;
			if (bus.off == `DMACR_OFF_CRC_VALUE) crc_value <= bus.wdata;
			if (bus.off == `DMACR_OFF_CRC_POST)  crc_post  <= bus.wdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_CURSOR_ADVANCE: assert property (@(posedge clk_sys) disable iff (reset)
		(bus.adv && inc_mem && !w_cur && !engine_reset) |=> cursor == $past(adv_sum))
		else $error("cursor did not advance by transfer size");
	AST_CURSOR_HIGH_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
		cursor[31:24] == 8'h00) else $error("cursor reserved bits set");
endmodule : dmacr_bank

`default_nettype wire

// ==== logic/dmacr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmacr_params.svh"

// Functional notes
// - Main bank at 2400h: control, staged word
// - Seven channel banks from 2440h, 40h apart
// - Soft reset bit self-clears, write-only
// - Global enable gates all channels, resets low
// - Channel runs when own and global enable
// - Read-only view of staged data word
// - Cursor advances per packet by transfer size
// - Memory side is transfer slave endpoint
// - Only 24 address bits implemented
// - Checksum registers exist in channel 0 only
// - Fixed offsets inside each channel bank
// - Engine reset on system or soft reset
module dmacr_top (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	// Register port
	input  wire logic [31:0]            reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [31:0]            reg_wdata,
	output var  logic [31:0]            reg_rdata,
	output var  logic                   reg_rvalid,
	// Source side of the staging path
	input  wire logic                   src_valid,
	input  wire logic [2:0]             src_channel,
	input  wire logic [31:0]            src_data,
	output var  logic                   src_ready,
	// Destination side of the staging path
	output var  logic                   dst_valid,
	output var  logic [2:0]             dst_channel,
	output var  logic [31:0]            dst_data,
	input  wire logic                   dst_ready,
	// Status
	output var  logic [`DMACR_NUM_CH-1:0] chan_run,
	output var  logic                   engine_reset
);
	localparam int NCH = `DMACR_NUM_CH;
	localparam int BW  = $bits(dmacr_pkg::dmacr_beat_type);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic bank_hit(input logic [31:0] addr, input int n);
		logic [31:0] base;
		base = `DMACR_CH0_BASE + 32'(n) * `DMACR_CH_STRIDE;
		return addr[31:6] == base[31:6];
	endfunction : bank_hit

	localparam logic [31:0] MAIN_BASE = `DMACR_MAIN_BASE;

	wire        main_hit   = reg_addr[31:6] == MAIN_BASE[31:6];
	wire [5:0]  off        = reg_addr[5:0];
	wire        main_ctl   = main_hit && off == `DMACR_OFF_MAIN_CTL;
	wire        main_stg   = main_hit && off == `DMACR_OFF_STAGED;
	wire        soft_write = reg_wr && main_ctl && reg_wdata[`DMACR_BIT_SOFT];
	wire        act_write  = reg_wr && main_ctl && !reg_wdata[`DMACR_BIT_SOFT];

	logic                      global_enable;
	dmacr_pkg::dmacr_word_type staged_word;
	logic [NCH-1:0]            bank_sel;
	logic [NCH-1:0]            bank_enable;
	logic [31:0]               rd_chain [NCH+1];

	// ----------------------------------------
	// Main block registers
	// ----------------------------------------
	// Engine reset stands high through system reset and one edge after it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			engine_reset <= 1'b1;
		end else begin
			engine_reset <= soft_write;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			global_enable <= 1'b0;
		end else if (engine_reset) begin
			global_enable <= 1'b0;
		end else if (act_write) begin
			global_enable <= reg_wdata[`DMACR_BIT_ACTIVATE];
		end
	end

	// ----------------------------------------
	// Staging path
	// ----------------------------------------
	dmacr_pkg::dmacr_beat_type fifo_in;
	dmacr_pkg::dmacr_beat_type fifo_out;
	logic                      fifo_out_valid;
	wire                       dst_fire   = dst_valid && dst_ready;
	wire                       stage_load = fifo_out_valid && (!dst_valid || dst_ready);

	assign fifo_in.channel = src_channel;
	assign fifo_in.data    = src_data;

	dmacr_fifo #(
		.WIDTH (BW),
		.DEPTH (`DMACR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.clear     (engine_reset),
		.in_valid  (src_valid),
		.in_data   (fifo_in),
		.in_ready  (src_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out),
		.out_ready (stage_load)
	);

	// Output register doubles as the staged word
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dst_valid   <= 1'b0;
			dst_channel <= 3'h0;
			dst_data    <= `DMACR_WORD_RESET;
		end else if (engine_reset) begin
			dst_valid   <= 1'b0;
			dst_channel <= 3'h0;
			dst_data    <= `DMACR_WORD_RESET;
		end else if (stage_load) begin
			dst_valid   <= 1'b1;
			dst_channel <= fifo_out.channel;
			dst_data    <= fifo_out.data;
		end else if (dst_fire) begin
			dst_valid   <= 1'b0;
		end
	end

	assign staged_word = dst_data;

	// ----------------------------------------
	// Channel banks
	// ----------------------------------------
	assign rd_chain[0] =
		main_ctl ? {31'h0, global_enable} :
		main_stg ? staged_word :
		`DMACR_WORD_RESET;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			dmacr_chan_if chan_bus ();

			assign bank_sel[gi]     = bank_hit(reg_addr, gi);
			assign chan_bus.wr      = reg_wr && bank_sel[gi];
			assign chan_bus.off     = off;
			assign chan_bus.wdata   = reg_wdata;
			assign chan_bus.adv     = dst_fire && dst_channel == 3'(gi) && chan_run[gi];
			assign bank_enable[gi]  = chan_bus.enable;
			assign rd_chain[gi+1]   = rd_chain[gi] | (bank_sel[gi] ? chan_bus.rdata : `DMACR_WORD_RESET);

			dmacr_bank #(
				.HAS_CRC (gi == 0)
			) u_bank (
				.clk_sys      (clk_sys),
				.reset        (reset),
				.engine_reset (engine_reset),
				.bus          (chan_bus.bank)
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			chan_run <= '0;
		end else begin
			chan_run <= bank_enable & {NCH{global_enable}};
		end
	end

	// ----------------------------------------
	// Register read answer
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata  <= `DMACR_WORD_RESET;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= reg_rd ? rd_chain[NCH] : `DMACR_WORD_RESET;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_soft_write;
		soft_write;
	endsequence

	sequence s_quiet;
		!soft_write;
	endsequence

	wire unmapped = !main_hit && bank_sel == '0;
	wire crc_hole = bank_hit(reg_addr, 1) && off >= `DMACR_OFF_CRC_EN && off <= `DMACR_OFF_CRC_TEST;

	AST_SOFT_SELF_CLEAR: assert property (
		s_soft_write ##1 s_quiet |-> engine_reset ##1 !engine_reset)
		else $error("soft reset did not self clear");
	AST_ENGINE_CLEARS_ENABLE: assert property (
		engine_reset |=> !global_enable && bank_enable == '0 ##1 chan_run == '0)
		else $error("engine reset left enables set");
	AST_GLOBAL_GATES: assert property (
		!global_enable |=> chan_run == '0)
		else $error("channel ran without global enable");
	AST_CHANNEL_RUN: assert property (
		chan_run == $past(bank_enable & {NCH{global_enable}}))
		else $error("channel run mismatch");
	AST_ACTIVATE_WRITE: assert property (
		act_write && !engine_reset |=> global_enable == $past(reg_wdata[`DMACR_BIT_ACTIVATE]))
		else $error("global enable write lost");
	AST_STAGED_READ: assert property (
		reg_rd && main_stg |=> reg_rvalid && reg_rdata == $past(dst_data))
		else $error("staged word read wrong");
	AST_UNMAPPED_ZERO: assert property (
		reg_rd && unmapped |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_CRC_HOLE_ZERO: assert property (
		reg_rd && crc_hole |=> reg_rdata == 32'h0000_0000)
		else $error("channel 1 checksum hole not zero");
	AST_SOFT_WRITE_ONLY: assert property (
		reg_rd && main_ctl |=> reg_rdata[`DMACR_BIT_SOFT] == 1'b0)
		else $error("soft reset bit readable");
	AST_STAGE_HOLD: assert property (
		dst_valid && !dst_ready && !engine_reset |=> dst_valid && $stable(dst_data))
		else $error("staged word changed while stalled");

	// ----------------------------------------
	// Read answer, engine reset and enable checks
	// ----------------------------------------
	AST_READ_ANSWER: assert property (
		reg_rd |=> reg_rvalid)
		else $error("read not answered");
	AST_IDLE_ANSWER: assert property (
		!reg_rd |=> !reg_rvalid && reg_rdata == 32'h0000_0000)
		else $error("answer without read");
	AST_MAIN_CTL_READ: assert property (
		reg_rd && main_ctl |=> reg_rdata == {31'h0, $past(global_enable)})
		else $error("global control read wrong");
	AST_SOFT_KEEPS_ENABLE: assert property (
		soft_write && !engine_reset |=> global_enable == $past(global_enable))
		else $error("soft reset write stored enable");
	AST_ENGINE_PULSE: assert property (
		!soft_write |=> !engine_reset)
		else $error("engine reset without soft reset");
	AST_ENGINE_FLUSH: assert property (
		engine_reset |=> !dst_valid && !src_ready)
		else $error("engine reset left staging path busy");
	AST_RUN_OFF_WITHOUT_BANK: assert property (
		bank_enable == '0 |=> chan_run == '0)
		else $error("channel ran without own enable");
	AST_UNMAPPED_WRITE_QUIET: assert property (
		reg_wr && unmapped && !engine_reset |=>
			global_enable == $past(global_enable) && bank_enable == $past(bank_enable))
		else $error("unmapped write changed an enable");

	// ----------------------------------------
	// Staging checks
	// ----------------------------------------
	sequence s_stage_take;
		stage_load && !engine_reset;
	endsequence

	AST_STAGE_LOAD: assert property (
		s_stage_take |=> dst_valid && dst_data == $past(fifo_out.data) &&
			dst_channel == $past(fifo_out.channel))
		else $error("staged word not loaded from buffer");
	AST_STAGE_DROP: assert property (
		dst_fire && !fifo_out_valid && !engine_reset |=> !dst_valid)
		else $error("staged word offered twice");
	AST_STAGED_READ_ONLY: assert property (
		reg_wr && main_stg && !stage_load && !engine_reset |=> $stable(dst_data))
		else $error("staged word written by software");

	// ----------------------------------------
	// Channel enable checks
	// ----------------------------------------
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chk
			AST_BANK_ENABLE_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
				reg_wr && bank_sel[gi] && off == `DMACR_OFF_CH_ENABLE && !engine_reset
					|=> bank_enable[gi] == $past(reg_wdata[`DMACR_BIT_CH_ENABLE]))
				else $error("channel enable write lost");
			AST_BANK_ENABLE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
				!(reg_wr && bank_sel[gi]) && !engine_reset |=> $stable(bank_enable[gi]))
				else $error("channel enable changed without write");
		end
	endgenerate
endmodule : dmacr_top

`default_nettype wire

// ==== verif/dmacr_peer.sv ====
`timescale 1ns/1ps
`default_nettype none

module dmacr_peer (
	// Clock
	input  wire logic        clk_sys,
	// Source side
	output var  logic        src_valid,
	output var  logic [2:0]  src_channel,
	output var  logic [31:0] src_data,
	input  wire logic        src_ready,
	// Destination side
	output var  logic        dst_ready,
	// Bench stall request
	input  wire logic        stall
);
	dmacr_pkg::dmacr_beat_type pend[$];

	initial begin
		src_valid = 1'b0;
		src_channel = 3'h0;
		src_data = 32'h0000_0000;
		dst_ready = 1'b0;
	end

	task automatic push(input dmacr_pkg::dmacr_beat_type b);
		pend.push_back(b);
	endtask : push

	// Offer words in order, each held until taken; idle lines keep toggling
	always @(posedge clk_sys) begin
		if (src_valid && src_ready)
			pend.delete(0);
		if (pend.size() > 0) begin
			src_valid <= 1'b1;
			src_channel <= pend[0].channel;
			src_data <= pend[0].data;
		end else begin
			src_valid <= 1'b0;
			src_channel <= ~src_channel;
			src_data <= ~src_data;
		end
		dst_ready <= !stall && ($urandom_range(3) != 0);
	end
endmodule : dmacr_peer

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [31:0] reg_addr = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic        reg_rvalid;
	logic        src_valid;
	logic [2:0]  src_channel;
	logic [31:0] src_data;
	logic        src_ready;
	logic        dst_valid;
	logic [2:0]  dst_channel;
	logic [31:0] dst_data;
	logic        dst_ready;
	logic [6:0]  chan_run;
	logic        engine_reset;
	logic        stall = 1'b0;
	int          err_count = 0;
	int          n_tests = 0;
	logic [31:0] exp_rd[$];
	dmacr_pkg::dmacr_beat_type exp_bt[$];
	logic [31:0] d;
	logic [31:0] last;

	always #5 clk_sys = ~clk_sys;

	dmacr_top dmacr_top_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.src_valid(src_valid), .src_channel(src_channel), .src_data(src_data), .src_ready(src_ready),
		.dst_valid(dst_valid), .dst_channel(dst_channel), .dst_data(dst_data), .dst_ready(dst_ready),
		.chan_run(chan_run), .engine_reset(engine_reset));

	dmacr_peer dmacr_peer_inst (.clk_sys(clk_sys), .src_valid(src_valid), .src_channel(src_channel),
		.src_data(src_data), .src_ready(src_ready), .dst_ready(dst_ready), .stall(stall));

	task automatic cmp(input logic [34:0] got, input logic [34:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	function automatic logic [31:0] ca(input int n, input logic [5:0] off);
		return 32'h0000_2440 + 32'(n) * 32'h0000_0040 + {26'h0, off};
	endfunction : ca

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_rd.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic send(input logic [2:0] c);
		dmacr_pkg::dmacr_beat_type b;
		b.channel = c;
		b.data = $urandom;
		last = b.data;
		exp_bt.push_back(b);
		dmacr_peer_inst.push(b);
	endtask : send

	task automatic drain();
		for (int i = 0; i < 400 && exp_bt.size() > 0; i++)
			@(posedge clk_sys);
		cmp({34'h0, exp_bt.size() == 0}, 35'h1, "staging path stuck");
	endtask : drain

	// Results are taken off the notes in arrival order
	always @(posedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_rd.size() == 0)
				cmp(35'h1, 35'h0, "stray read answer");
			else
				cmp({3'h0, reg_rdata}, {3'h0, exp_rd.pop_front()}, "read data");
		end
		if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
			if (exp_bt.size() == 0)
				cmp(35'h1, 35'h0, "stray staged beat");
			else
				cmp({dst_channel, dst_data}, exp_bt.pop_front(), "staged beat");
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'h6a8c));
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		// ----------------------------------------
		// Reset values
		// ----------------------------------------
		rd(32'h0000_2400, 32'h0000_0000);
		rd(32'h0000_2404, 32'h0000_0000);
		for (int n = 0; n < 7; n++) begin
			rd(ca(n, 6'h00), 32'h0000_0000);
			rd(ca(n, 6'h04), 32'h0000_0000);
		end
		$display("end of test reset_values");
		// ----------------------------------------
		// Channel map, widths, reserved space
		// ----------------------------------------
		for (int n = 0; n < 7; n++) begin
			for (int o = 4; o <= 12; o += 4) begin
				d = $urandom;
				wr(ca(n, 6'(o)), d);
				rd(ca(n, 6'(o)), d & 32'h00ff_ffff);
			end
			for (int o = 28; o <= 44; o += 4) begin
				d = $urandom;
				wr(ca(n, 6'(o)), d);
				rd(ca(n, 6'(o)), (n == 0 && o >= 32 && o <= 40) ? d : 32'h0000_0000);
			end
		end
		wr(32'h0000_2600, 32'hffff_ffff);
		rd(32'h0000_2600, 32'h0000_0000);
		rd(32'h0000_2408, 32'h0000_0000);
		wr(32'h0000_2404, 32'hffff_ffff);
		rd(32'h0000_2404, 32'h0000_0000);
		rd(ca(0, 6'h05), 32'h0000_0000);
		$display("end of test register_map");
		// ----------------------------------------
		// Global and channel enables
		// ----------------------------------------
		wr(ca(2, 6'h00), 32'h0000_0001);
		repeat (3) @(posedge clk_sys);
		cmp({28'h0, chan_run}, 35'h0, "run without global enable");
		wr(32'h0000_2400, 32'h0000_0001);
		rd(32'h0000_2400, 32'h0000_0001);
		repeat (3) @(posedge clk_sys);
		cmp({28'h0, chan_run}, 35'h4, "run with both enables");
		wr(32'h0000_2400, 32'h0000_0000);
		repeat (3) @(posedge clk_sys);
		cmp({28'h0, chan_run}, 35'h0, "run after global disable");
		$display("end of test enables");
		// ----------------------------------------
		// Traffic and cursor advance
		// ----------------------------------------
		wr(32'h0000_2400, 32'h0000_0001);
		wr(ca(0, 6'h00), 32'h0000_0001);
		wr(ca(0, 6'h04), 32'h00ff_fffc);
		wr(ca(0, 6'h10), 32'h0041_0000);
		wr(ca(1, 6'h00), 32'h0000_0000);
		wr(ca(1, 6'h04), 32'h0000_0010);
		wr(ca(1, 6'h10), 32'h0041_0000);
		rd(ca(0, 6'h10), 32'h0041_0000);
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 5; i++)
			send(3'(i % 2));
		drain();
		rd(ca(0, 6'h04), 32'h0000_0008);
		rd(ca(1, 6'h04), 32'h0000_0010);
		rd(32'h0000_2404, last);
		$display("end of test traffic");
		// ----------------------------------------
		// Buffer fill with the far side stalled
		// ----------------------------------------
		stall <= 1'b1;
		for (int i = 0; i < 12; i++)
			send(3'h3);
		repeat (30) @(posedge clk_sys);
		cmp({34'h0, src_ready}, 35'h0, "buffer not refusing");
		stall <= 1'b0;
		drain();
		rd(32'h0000_2404, last);
		$display("end of test buffer_fill");
		// ----------------------------------------
		// Soft reset
		// ----------------------------------------
		wr(32'h0000_2400, 32'h0000_0003);
		#1;
		cmp({34'h0, engine_reset}, 35'h1, "engine reset after soft reset");
		rd(32'h0000_2400, 32'h0000_0000);
		rd(ca(0, 6'h00), 32'h0000_0000);
		rd(ca(0, 6'h04), 32'h0000_0000);
		rd(ca(0, 6'h10), 32'h0000_0000);
		repeat (4) @(posedge clk_sys);
		cmp({28'h0, chan_run}, 35'h0, "run after soft reset");
		$display("end of test soft_reset");
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
